// ### hdl/interval_timer_defs.svh
`ifndef INTERVAL_TIMER_DEFS_SVH
`define INTERVAL_TIMER_DEFS_SVH

// register byte offsets on the apb bus
`define TIMER_CONTROL_OFS 12'h000
`define INTERVAL_COMPARE_OFS 12'h004
`define ADDR_DECODE_W 12

// timer_control field layout
`define CTRL_ENABLE_BIT 7
`define CTRL_SEL_LSB 0
`define CTRL_SEL_MSB 2
`define CTRL_WRITABLE_MASK 8'h87

// reset values
`define TIMER_CONTROL_RST 8'h00
`define INTERVAL_COMPARE_RST 16'h0000
`define INTERVAL_COMPARE_STOP_RST 16'hffff
`define COUNTER_IDLE 16'hffff
`define COUNTER_ZERO 16'h0000

// prescaler taps for the main clock divisions
`define PRESCALE_W 9
`define TAP_DIV2 0
`define TAP_DIV4 1
`define TAP_DIV64 5
`define TAP_DIV512 8
`define OSC_DIV_W 3

`endif

// ### hdl/interval_timer_pkg.sv
package interval_timer_pkg;

  // count clock sources of the select field
  typedef enum logic [2:0] {
    SEL_MAIN = 3'h0,
    SEL_DIV2 = 3'h1,
    SEL_DIV4 = 3'h2,
    SEL_DIV64 = 3'h3,
    SEL_DIV512 = 3'h4,
    SEL_WATCH = 3'h5,
    SEL_OSC8 = 3'h6,
    SEL_SUB = 3'h7
  } clk_sel_t;

  // apb access sequencing
  typedef enum logic {
    BUS_IDLE,
    BUS_ANSWER
  } bus_state_t;

endpackage : interval_timer_pkg

// ### hdl/count_tick_if.sv
`timescale 1ns/1ns
// carries the chosen source and run level down, the count tick back up
interface count_tick_if;
  interval_timer_pkg::clk_sel_t sel;
  logic run;
  logic tick;
  modport timer(output sel, output run, input tick);
  modport source(input sel, input run, output tick);
endinterface : count_tick_if

// ### hdl/count_clock_select.sv
`timescale 1ns/1ns
`include "interval_timer_defs.svh"
module count_clock_select (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic watch_tick_signal,
  input wire logic internal_osc_clk,
  input wire logic sub_clock,
  count_tick_if.source link
);

  logic [`PRESCALE_W-1:0] pre_q, pre_d;
  logic [`OSC_DIV_W-1:0] osc_q, osc_d;
  logic osc_prev_q, osc_prev_d;
  logic sub_prev_q, sub_prev_d;
  logic watch_prev_q, watch_prev_d;
  logic tick_q, tick_d;
  logic [`PRESCALE_W-1:0] pre_inc;
  logic osc_rise, sub_rise, watch_rise, osc_wrap;

  //////////////////////////////////////////////////////////////////////////////
  // prescaler and edge detection; the prescaler and osc/8 divider are held in reset
  // while stopped so the start latency is the same each time
  always_comb begin
    pre_inc = pre_q + `PRESCALE_W'(1);
    osc_rise = internal_osc_clk & ~osc_prev_q;
    sub_rise = sub_clock & ~sub_prev_q;
    watch_rise = watch_tick_signal & ~watch_prev_q;
    osc_wrap = osc_rise && (osc_q == {`OSC_DIV_W{1'b1}});
    osc_prev_d = internal_osc_clk;
    sub_prev_d = sub_clock;
    watch_prev_d = watch_tick_signal;
    pre_d = link.run ? pre_inc : '0;
    osc_d = !link.run ? '0 : (osc_rise ? osc_q + `OSC_DIV_W'(1) : osc_q);
    // a carry into a tap bit marks one period of that division
    unique case (link.sel)
      interval_timer_pkg::SEL_MAIN: tick_d = 1'b1;
      interval_timer_pkg::SEL_DIV2: tick_d = pre_inc[`TAP_DIV2] & ~pre_q[`TAP_DIV2];
      interval_timer_pkg::SEL_DIV4: tick_d = pre_inc[`TAP_DIV4] & ~pre_q[`TAP_DIV4];
      interval_timer_pkg::SEL_DIV64: tick_d = pre_inc[`TAP_DIV64] & ~pre_q[`TAP_DIV64];
      interval_timer_pkg::SEL_DIV512: tick_d = pre_inc[`TAP_DIV512] & ~pre_q[`TAP_DIV512];
      interval_timer_pkg::SEL_WATCH: tick_d = watch_rise;
      interval_timer_pkg::SEL_OSC8: tick_d = osc_wrap;
      interval_timer_pkg::SEL_SUB: tick_d = sub_rise;
    endcase
    // stopped timer keeps its internal clock low
    if (!link.run) begin
      tick_d = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= '0;
      osc_q <= '0;
      osc_prev_q <= 1'b0;
      sub_prev_q <= 1'b0;
      watch_prev_q <= 1'b0;
      tick_q <= 1'b0;
    end else begin
      pre_q <= pre_d;
      osc_q <= osc_d;
      osc_prev_q <= osc_prev_d;
      sub_prev_q <= sub_prev_d;
      watch_prev_q <= watch_prev_d;
      tick_q <= tick_d;
    end
  end

  assign link.tick = tick_q;

endmodule : count_clock_select

// ### hdl/interval_timer_unit.sv
// How it works
// - one 16-bit up-counter runs on the chosen count tick and software can never see it.
// - the counter only clears and restarts on a compare match; there is no free-run mode.
// - select field 0..7 picks main, main/2, /4, /64, /512, watch tick, osc/8, subclock.
// - enable low stops the tick, holds it low and forces the counter to its idle value.
// - the 8-bit control register reads and writes by byte or bit and resets to 00h.
// - while running, only the enable bit of the control register may change.
// - compare is written only as a whole 16-bit word; reset gives 0000h, ffffh if stopped.
// - compare is not changed while running; rewriting the held value is always fine.
// - the counter follows the chosen source and raises a request each interval.
// - on start the counter goes from ffffh to 0000h on a tick and then counts up.
// - when counter equals compare, the next tick clears it and raises the match request.
// - with compare zero the counter sits at zero and every tick raises the request.
//
// The APB register port and the placing of the registers were decided locally.
`timescale 1ns/1ns
`include "interval_timer_defs.svh"
module interval_timer_unit #(
  parameter int CNT_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic unit_reset,
  input wire logic watch_tick_signal,
  input wire logic internal_osc_clk,
  input wire logic sub_clock,
  output logic match_interrupt
);

  count_tick_if link ();

  //////////////////////////////////////////////////////////////////////////////
  // state
  interval_timer_pkg::bus_state_t bus_q, bus_d;
  logic [7:0] control_q, control_d;
  logic [CNT_W-1:0] compare_q, compare_d;
  logic [CNT_W-1:0] counter_q, counter_d;
  logic [31:0] prdata_q, prdata_d;
  logic pslverr_q, pslverr_d;
  logic irq_q, irq_d;

  logic running;
  logic commit;
  logic hit_ctrl, hit_cmp;
  logic [7:0] wr_ctrl;
  logic [CNT_W-1:0] wr_cmp;

  assign running = control_q[`CTRL_ENABLE_BIT];

  //////////////////////////////////////////////////////////////////////////////
  // count clock source
  assign link.sel = interval_timer_pkg::clk_sel_t'(control_q[`CTRL_SEL_MSB:`CTRL_SEL_LSB]);
  assign link.run = running;

  count_clock_select u_src (
    .pclk(pclk),
    .presetn(presetn),
    .watch_tick_signal(watch_tick_signal),
    .internal_osc_clk(internal_osc_clk),
    .sub_clock(sub_clock),
    .link(link)
  );

  //////////////////////////////////////////////////////////////////////////////
  // apb slave: one wait state, so pready answers on the second access cycle
  always_comb begin
    hit_ctrl = paddr[`ADDR_DECODE_W-1:0] == `TIMER_CONTROL_OFS;
    hit_cmp = paddr[`ADDR_DECODE_W-1:0] == `INTERVAL_COMPARE_OFS;
    commit = (bus_q == interval_timer_pkg::BUS_ANSWER);
    bus_d = bus_q;
    prdata_d = prdata_q;
    pslverr_d = 1'b0;
    unique case (bus_q)
      interval_timer_pkg::BUS_IDLE: begin
        if (psel && penable) begin
          bus_d = interval_timer_pkg::BUS_ANSWER;
          // writes leave the last read data standing
          if (!pwrite) begin
            prdata_d = '0;
            // the counter itself has no address
            if (hit_ctrl) begin
              prdata_d[7:0] = control_q;
            end else if (hit_cmp) begin
              prdata_d[CNT_W-1:0] = compare_q;
            end
          end
          // unmapped addresses answer with an error
          pslverr_d = !(hit_ctrl || hit_cmp);
        end
      end
      interval_timer_pkg::BUS_ANSWER: begin
        bus_d = interval_timer_pkg::BUS_IDLE;
        pslverr_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_q <= interval_timer_pkg::BUS_IDLE;
      prdata_q <= '0;
      pslverr_q <= 1'b0;
    end else begin
      bus_q <= bus_d;
      prdata_q <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign pready = commit;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;

  //////////////////////////////////////////////////////////////////////////////
  // register writes, taken at the edge where pready is seen high
  always_comb begin
    control_d = control_q;
    compare_d = compare_q;
    // bits 3..6 are not stored, so they always read zero
    wr_ctrl = pwdata[7:0] & `CTRL_WRITABLE_MASK;
    wr_cmp = pwdata[CNT_W-1:0];
    if (commit && pwrite && hit_ctrl && pstrb[0]) begin
      // byte lane 0 carries the whole control byte
      if (running) begin
        // only the enable may change; other bits keep their value
        control_d[`CTRL_ENABLE_BIT] = wr_ctrl[`CTRL_ENABLE_BIT];
      end else begin
        control_d = wr_ctrl;
      end
    end
    if (commit && pwrite && hit_cmp && (pstrb[1:0] == 2'h3)) begin
      // single-byte writes are dropped; only a write with both low byte lanes lands
      if (!running || (wr_cmp == compare_q)) begin
        compare_d = wr_cmp;
      end
    end
    // unit reset: stopped timer loads ffffh, a running one 0000h
    if (unit_reset) begin
      control_d = `TIMER_CONTROL_RST;
      compare_d = running ? `INTERVAL_COMPARE_RST : `INTERVAL_COMPARE_STOP_RST;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_q <= `TIMER_CONTROL_RST;
      compare_q <= `INTERVAL_COMPARE_RST;
    end else begin
      control_q <= control_d;
      compare_q <= compare_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // counter and match; clear-and-start is the only behaviour
  // the stop clear is synchronous to pclk: one cycle late against the
  // documented asynchronous clear, which no tick can observe anyway
  always_comb begin
    counter_d = counter_q;
    irq_d = 1'b0;
    if (!running) begin
      counter_d = `COUNTER_IDLE;
    end else if (link.tick) begin
      if (counter_q == compare_q) begin
        // match clears on this tick and raises one pulse
        counter_d = `COUNTER_ZERO;
        irq_d = 1'b1;
      end else begin
        // idle ffffh wraps to 0000h on the first tick
        counter_d = counter_q + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_q <= `COUNTER_IDLE;
      irq_q <= 1'b0;
    end else begin
      counter_q <= counter_d;
      irq_q <= irq_d;
    end
  end

  assign match_interrupt = irq_q;

endmodule : interval_timer_unit

// ### tb/interval_timer_monitor.sv
`timescale 1ns/1ns
module interval_timer_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic unit_reset,
  input wire logic match_interrupt
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic en_q;
  logic [2:0] sel_q;
  logic [15:0] cmp_q;
  logic [3:0] cnt_q;
  wire acc = psel && penable && pready;
  wire at_ctl = paddr[11:0] == 12'h000;
  wire at_cmp = paddr[11:0] == 12'h004;
  wire wr_ctl = acc && pwrite && at_ctl && pstrb[0];
  wire wr_cmp = acc && pwrite && at_cmp && pstrb[1:0] == 2'h3;
  ////////////////////////////////////////////////////////////////////////
  // shadow of the register state; cnt_q saturates, counts since enable moved
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= 1'b0;
      sel_q <= 3'h0;
      cmp_q <= 16'h0000;
      cnt_q <= 4'h0;
    end else if (unit_reset) begin
      en_q <= 1'b0;
      sel_q <= 3'h0;
      cmp_q <= en_q ? 16'h0000 : 16'hffff;
      cnt_q <= 4'h0;
    end else begin
      en_q <= wr_ctl ? pwdata[7] : en_q;
      sel_q <= (wr_ctl && !en_q) ? pwdata[2:0] : sel_q;
      cmp_q <= (wr_cmp && (!en_q || pwdata[15:0] == cmp_q)) ? pwdata[15:0] : cmp_q;
      cnt_q <= (wr_ctl && pwdata[7] != en_q) ? 4'h0 : cnt_q + {3'h0, cnt_q != 4'hf};
    end
  end
  ////////////////////////////////////////////////////////////////////////
  sequence s_wait;
    !match_interrupt [*5];
  endsequence
  sequence s_gap;
    !match_interrupt [*2] ##1 match_interrupt;
  endsequence
  property p_ready_next; psel && penable && !pready |=> pready; endproperty
  property p_ready_one; pready |=> !pready; endproperty
  property p_err; acc |-> pslverr == !(at_ctl || at_cmp); endproperty
  property p_ctl_read; acc && !pwrite && at_ctl |-> prdata[7:0] == {en_q, 4'h0, sel_q}; endproperty
  property p_cmp_read; acc && !pwrite && at_cmp |-> prdata[15:0] == cmp_q; endproperty
  property p_rd_hold; !(psel && penable && !pwrite && !pready) |=> $stable(prdata); endproperty
  property p_quiet; !en_q && cnt_q > 4'h3 |-> !match_interrupt; endproperty
  property p_zero; en_q && sel_q == 3'h0 && cmp_q == 16'h0 && cnt_q > 4'h7 |-> match_interrupt;
  endproperty
  property p_first;
    $rose(en_q) && sel_q == 3'h0 && cmp_q == 16'h2 |-> s_wait ##1 match_interrupt ##1 s_gap;
  endproperty
  property p_pulse; match_interrupt && cmp_q != 16'h0 |=> !match_interrupt; endproperty
  a_ready_next: assert property (p_ready_next) else $error("no answer");
  a_ready_one: assert property (p_ready_one) else $error("ready too long");
  a_err: assert property (p_err) else $error("bad error flag");
  a_ctl_read: assert property (p_ctl_read) else $error("bad control");
  a_cmp_read: assert property (p_cmp_read) else $error("bad compare");
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  a_quiet: assert property (p_quiet) else $error("irq while stopped");
  a_zero: assert property (p_zero) else $error("missing irq");
  a_first: assert property (p_first) else $error("bad start");
  a_pulse: assert property (p_pulse) else $error("irq too long");
endmodule : interval_timer_monitor

// ### tb/test_interval_timer_unit.sv
`timescale 1ns/1ns
module test_interval_timer_unit;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'h0;
  logic pready, pslverr, match_interrupt, err, unit_reset = 1'b0;
  logic watch_tick_signal = 1'b0, internal_osc_clk = 1'b0, sub_clock = 1'b0;
  int fails = 0, num_checks = 0, cyc = 0, n;
  int period [8] = '{1, 2, 4, 64, 512, 8, 32, 6};
  always #20 pclk = ~pclk;
  interval_timer_unit DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .unit_reset(unit_reset),
    .watch_tick_signal(watch_tick_signal), .internal_osc_clk(internal_osc_clk),
    .sub_clock(sub_clock), .match_interrupt(match_interrupt));
  ////////////////////////////////////////////////////////////////////////
  // slow sources: watch tick every 8, osc/8 every 32, subclock every 6
  always @(posedge pclk) begin
    cyc = cyc + 1;
    watch_tick_signal <= (cyc % 8) < 4;
    internal_osc_clk <= (cyc % 4) < 2;
    sub_clock <= (cyc % 6) < 3;
    if (cyc == 30000) begin
      fails++;
      close_out();
    end
  end
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer, then an idle edge so the next setup never collides
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
    input logic [3:0] s = 4'hf);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {20'h0, a};
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : bus
  task automatic wait_irq;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (match_interrupt !== 1'b1);
  endtask : wait_irq
  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    bus(0, 12'h000, 0); chk(rd, 0);
    bus(0, 12'h004, 0); chk(rd, 0);
    bus(0, 12'h008, 0); chk(err, 1);
    bus(1, 12'h004, 32'h1234, 4'h1);
    bus(0, 12'h004, 0); chk(rd, 0);
    bus(1, 12'h000, 32'h05);
    bus(1, 12'h000, 32'h85);
    bus(1, 12'h000, 32'h82);
    bus(0, 12'h000, 0); chk(rd, 32'h85);
    bus(1, 12'h004, 32'h1234);
    bus(0, 12'h004, 0); chk(rd, 0);
    bus(1, 12'h000, 32'h00);
    bus(0, 12'h000, 0); chk(rd, 32'h05);
    $display("test regs done");
  endtask : t_regs
  // compare 2 gives a period of three count ticks for every source
  task automatic t_src;
    for (int i = 0; i < 8; i++) begin
      bus(1, 12'h000, i); // select only while stopped, bits 3..6 zero
      bus(1, 12'h004, 32'h2);
      bus(1, 12'h000, 32'h80 | i); // start keeps the select unchanged
      wait_irq();
      if (i == 0) chk(n, 5);
      wait_irq();
      chk(n, 3 * period[i]);
      bus(1, 12'h000, 0);
    end
    repeat (4) @(posedge pclk);
    repeat (20) begin
      @(posedge pclk);
      chk(match_interrupt, 0);
    end
    $display("test sources done");
  endtask : t_src
  task automatic t_zero;
    bus(1, 12'h004, 0);
    bus(1, 12'h000, 0); // select back to main clock while stopped
    bus(1, 12'h000, 32'h80);
    wait_irq(); chk(n, 3);
    repeat (8) begin
      @(posedge pclk);
      chk(match_interrupt, 1);
    end
    bus(1, 12'h000, 0);
    $display("test zero done");
  endtask : t_zero
  // the unit reset loads ffffh only when the timer was stopped
  task automatic t_ureset;
    unit_reset <= 1'b1;
    @(posedge pclk);
    unit_reset <= 1'b0;
    bus(0, 12'h004, 0); chk(rd, 32'hffff);
    bus(1, 12'h000, 32'h80);
    unit_reset <= 1'b1;
    @(posedge pclk);
    unit_reset <= 1'b0;
    bus(0, 12'h004, 0); chk(rd, 0);
    bus(0, 12'h000, 0); chk(rd, 0);
    $display("test unit reset done");
  endtask : t_ureset
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_src();
    t_zero();
    t_ureset();
    close_out();
  end
endmodule : test_interval_timer_unit
bind interval_timer_unit interval_timer_monitor u_mon (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .unit_reset(unit_reset), .match_interrupt(match_interrupt));
